// ===== common/osdc_pkg.sv
/*
  Package of the octal serial driver control block: widths, the fault
  clear delay in its own unit and as cycles, and the reset values.
  Assumes a 40 MHz ref_clk; everything else is self contained.
*/
package osdc_pkg;
  // Number of driver channels and bits per transfer.
  localparam int unsigned CHAN_N = 8;
  // Clock rate in kHz, so that microseconds convert without overflow.
  localparam int unsigned CLK_KHZ = 40000;
  // Fault clear delay window in microseconds, least and longest.
  localparam int unsigned FAULT_CLEAR_DELAY_MIN_US = 75;
  localparam int unsigned FAULT_CLEAR_DELAY_MAX_US = 250;
  // Least delay rounded up to cycles; longest rounded down.
  localparam int unsigned FAULT_CLEAR_MIN_CYC =
    (FAULT_CLEAR_DELAY_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned FAULT_CLEAR_MAX_CYC =
    (FAULT_CLEAR_DELAY_MAX_US * CLK_KHZ) / 1000;
  // Delay used by the design: halfway between both bounds.
  localparam int unsigned FAULT_CLEAR_CYC =
    (FAULT_CLEAR_MIN_CYC + FAULT_CLEAR_MAX_CYC) / 2;
  // Reset values: latch all ones means every output OFF.
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  // Width of the fault delay counter.
  localparam int unsigned DLY_W = 14;
endpackage

// ===== common/osdc_link_if.sv
/*
  Interface carrying the synchronised link events from the pin sampler to
  the control core. Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface osdc_link_if;
  logic sel_q;     // Filtered select level, high while deselected.
  logic sel_fall;  // One-cycle pulse at a select falling edge.
  logic sel_rise;  // One-cycle pulse at a select rising edge.
  logic sclk_rise; // One-cycle pulse at a serial clock rising edge.
  logic sclk_fall; // One-cycle pulse at a serial clock falling edge.
  logic sdi;       // Filtered serial data input level.
  modport src (output sel_q, sel_fall, sel_rise, sclk_rise, sclk_fall, sdi);
  modport dst (input sel_q, sel_fall, sel_rise, sclk_rise, sclk_fall, sdi);
endinterface
`default_nettype wire

// ===== hw/osdc_pin_sync.sv
/*
  Pin sampler: three flip-flops per link pin, a change counts once the
  second and third stage agree. Produces edge pulses for the core.
  Assumes pins are asynchronous to ref_clk and far slower than it.
*/
`timescale 1ns/1ps
`default_nettype none
module osdc_pin_sync (
  input  wire logic     ref_clk,
  input  wire logic     rst_n,
  input  wire logic     sel_n_pin,
  input  wire logic     sclk_pin,
  input  wire logic     sdi_pin,
  osdc_link_if.src      lnk
);
  // Whole state of the sampler in one packed struct.
  typedef struct packed {
    logic [2:0] sel;  // Select sampling chain.
    logic [2:0] sclk; // Serial clock sampling chain.
    logic [2:0] sdi;  // Serial data sampling chain.
    logic       sel_f;  // Accepted select level.
    logic       sclk_f; // Accepted serial clock level.
    logic       sdi_f;  // Accepted data level.
  } osdc_sync_t;

  osdc_sync_t st_q;
  osdc_sync_t st_d;

  // Next state: shift chains; accept a level once stages one and two agree.
  // Stage zero is read only by stage one, keeping it a clean synchroniser.
  always_comb begin
    st_d = st_q;
    st_d.sel = {st_q.sel[1:0], sel_n_pin};
    st_d.sclk = {st_q.sclk[1:0], sclk_pin};
    st_d.sdi = {st_q.sdi[1:0], sdi_pin};
    if (st_q.sel[1] == st_q.sel[2]) begin
      st_d.sel_f = st_q.sel[2];
    end
    if (st_q.sclk[1] == st_q.sclk[2]) begin
      st_d.sclk_f = st_q.sclk[2];
    end
    if (st_q.sdi[1] == st_q.sdi[2]) begin
      st_d.sdi_f = st_q.sdi[2];
    end
  end

  // Registered state; reset takes deselected, clock low, data low.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= '{sel: 3'h7, sclk: 3'h0, sdi: 3'h0,
                sel_f: 1'b1, sclk_f: 1'b0, sdi_f: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // Edge pulses compare the accepted level with its next value.
  assign lnk.sel_q = st_q.sel_f;
  assign lnk.sel_fall = st_q.sel_f & ~st_d.sel_f;
  assign lnk.sel_rise = ~st_q.sel_f & st_d.sel_f;
  assign lnk.sclk_rise = ~st_q.sclk_f & st_d.sclk_f;
  assign lnk.sclk_fall = st_q.sclk_f & ~st_d.sclk_f;
  assign lnk.sdi = st_q.sdi_f;
endmodule
`default_nettype wire

// ===== hw/osdc_core.sv
/*
  Control core of an eight channel low side driver with a serial link:
  shift register, output latch, diagnostic load and delayed fault clear.
  Assumes the link pins are slow against the 40 MHz ref_clk and that the
  per-channel sense inputs already come as clean logic levels.
*/
`timescale 1ns/1ps
`default_nettype none
module osdc_core (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   sel_n,
  input  wire logic                   sclk,
  input  wire logic                   sdi,
  input  wire logic [osdc_pkg::CHAN_N-1:0] out_high,
  input  wire logic [osdc_pkg::CHAN_N-1:0] fault_threshold,
  output logic                        sdo,
  output logic                        sdo_oe,
  output logic [osdc_pkg::CHAN_N-1:0] drv_on
);
  import osdc_pkg::*;

  // Delay count as a sized constant for the counter.
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(FAULT_CLEAR_CYC - 1);

  // Synchronised link events shared with the pin sampler.
  osdc_link_if lnk ();

  // Pin sampler; all link pins are foreign to ref_clk.
  osdc_pin_sync u_sync (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .sel_n_pin (sel_n),
    .sclk_pin  (sclk),
    .sdi_pin   (sdi),
    .lnk       (lnk)
  );

  // Fault delay sequencer states.
  typedef enum logic [1:0] {
    FD_IDLE,
    FD_WAIT,
    FD_ARMED
  } osdc_fd_t;

  // Whole state of the core in one packed struct.
  typedef struct packed {
    logic [CHAN_N-1:0] shift;  // Shift register, bit 7 leaves first.
    logic [CHAN_N-1:0] latch;  // Output latch, one means OFF.
    logic              sdo;    // Serial output bit register.
    logic              sdo_oe; // Serial output enable register.
    osdc_fd_t          fd;     // Fault delay sequencer.
    logic [DLY_W-1:0]  dly;    // Fault delay counter.
  } osdc_core_t;

  osdc_core_t st_q;
  osdc_core_t st_d;

  // Sense as seen by the diagnostics: pin level, one when high.
  // An open OFF pin reads low because the sense cell pulls it down.
  logic [CHAN_N-1:0] sense;
  assign sense = out_high;

  // Channels that are ON yet sit above the fault threshold.
  logic [CHAN_N-1:0] fault;
  assign fault = ~st_q.latch & fault_threshold;

  // Next state of shifting, latching and fault clearing.
  always_comb begin
    st_d = st_q;
    // Output enable follows the filtered select level.
    st_d.sdo_oe = ~lnk.sel_q & ~lnk.sel_rise;
    if (lnk.sel_fall) begin
      // Jam diagnostics; channel seven sits at the top bit.
      st_d.shift = sense;
    end else if (!lnk.sel_q && lnk.sclk_rise) begin
      // Present the top bit; it is shifted out at the next fall.
      st_d.sdo = st_q.shift[CHAN_N-1];
    end else if (!lnk.sel_q && lnk.sclk_fall) begin
      // Take the input bit; the top bit leaves, so devices cascade.
      // No bit count is kept, so any number of clocks is accepted.
      st_d.shift = {st_q.shift[CHAN_N-2:0], lnk.sdi};
    end
    // Latch changes only here and at fault clear; shifting never
    // touches it, so outputs hold steady during a transfer.
    if (lnk.sel_rise) begin
      st_d.latch = st_q.shift;
      st_d.fd = FD_WAIT;
      st_d.dly = '0;
    end else begin
      case (st_q.fd)
        FD_WAIT: begin
          // Faults are ignored until the delay after select rise ends.
          if (st_q.dly == DLY_LAST) begin
            st_d.fd = FD_ARMED;
          end else begin
            st_d.dly = st_q.dly + DLY_W'(1);
          end
        end
        FD_ARMED: begin
          // Set every faulty channel's latch bit to one, turning it OFF.
          st_d.latch = st_q.latch | fault;
        end
        default: begin
          st_d.fd = FD_IDLE;
        end
      endcase
    end
  end

  // Registered state; reset puts all outputs OFF and empties the shifter.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= '{shift: SHIFT_RST, latch: LATCH_RST, sdo: 1'b0,
                sdo_oe: 1'b0, fd: FD_ARMED, dly: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Drive enable per channel: latch zero means ON.
  assign drv_on = ~st_q.latch;
  assign sdo = st_q.sdo;
  assign sdo_oe = st_q.sdo_oe;

  // Helper: cycles since the last select rise, saturating.
  logic [DLY_W-1:0] since_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      since_q <= '1;
    end else if (lnk.sel_rise) begin
      since_q <= '0;
    end else if (since_q != '1) begin
      since_q <= since_q + DLY_W'(1);
    end
  end

  // Select rise copies the shift register into the latch.
  chk_latch_load: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    lnk.sel_rise |=> st_q.latch == $past(st_q.shift))
    else $error("latch did not take shift register at select rise");

  // Select fall jams the sense levels into the shifter.
  chk_diag_load: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    lnk.sel_fall |=> st_q.shift == $past(sense))
    else $error("shift register missed diagnostic load");

  // A deselected device must leave the serial output floating.
  chk_sdo_hiz: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    lnk.sel_q |=> !sdo_oe)
    else $error("serial output driven while deselected");

  // A selected clock rise presents the top bit of the shifter.
  chk_sdo_bit: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (!lnk.sel_q && lnk.sclk_rise && !lnk.sel_fall)
      |=> sdo == $past(st_q.shift[CHAN_N-1]))
    else $error("serial output not the top shift bit after clock rise");

  // A selected clock fall shifts the input bit in at the bottom.
  chk_shift_in: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (!lnk.sel_q && lnk.sclk_fall && !lnk.sel_fall)
      |=> st_q.shift == {$past(st_q.shift[CHAN_N-2:0]), $past(lnk.sdi)})
    else $error("serial input not shifted in at clock fall");

  // No latch bit may move before the least fault delay has passed.
  chk_fault_early: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (since_q < DLY_W'(FAULT_CLEAR_MIN_CYC) && !lnk.sel_rise)
      |=> $stable(st_q.latch))
    else $error("fault cleared a latch bit before the least delay");

  // A fault still present at the longest delay must be cleared.
  chk_fault_late: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (since_q == DLY_W'(FAULT_CLEAR_MAX_CYC) && |fault && !lnk.sel_rise)
      |=> (st_q.latch & $past(fault)) == $past(fault))
    else $error("fault not cleared by the longest delay");

  // Without a select rise or a fault the outputs hold their state.
  chk_latch_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (!lnk.sel_rise && ~|fault) |=> $stable(drv_on))
    else $error("outputs changed without select rise or fault");

  // Serial output is enabled on the cycle after any selected cycle without a select rise.
  chk_sdo_drive: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (!lnk.sel_q && !lnk.sel_rise) |=> sdo_oe)
    else $error("serial output not driven while selected");

  // Between selected clock rises the serial output bit stands still.
  chk_sdo_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (lnk.sel_q || !lnk.sclk_rise || lnk.sel_fall) |=> $stable(sdo))
    else $error("serial output changed without a clock rise");

  // The shifter moves only at a diagnostic load or a selected fall.
  chk_shift_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (!lnk.sel_fall && (lnk.sel_q || !lnk.sclk_fall))
      |=> $stable(st_q.shift))
    else $error("shift register moved without a clock fall");

  // While the fault delay runs, no fault may touch the latch.
  chk_fault_wait: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (st_q.fd == FD_WAIT && !lnk.sel_rise) |=> $stable(st_q.latch))
    else $error("latch changed while the fault delay ran");

  // Once armed, every faulty channel is turned OFF on the next cycle.
  chk_fault_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (st_q.fd == FD_ARMED && !lnk.sel_rise)
      |=> (st_q.latch & $past(fault)) == $past(fault))
    else $error("armed fault did not turn its channel OFF");
endmodule
`default_nettype wire

// ===== sim/osdc_host_model.sv
/*
  Host link master model: one select pulse per frame, n bits MSB first.
  Assumes ref_clk only triggers a frame; link timing runs on own delays.
*/
`timescale 1ns/1ps
`default_nettype none
module osdc_host_model (
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic [4:0]  n_bits,
  input  wire logic [15:0] tx,
  input  wire logic        sdo_w,
  output logic             sel_n,
  output logic             sclk,
  output logic             sdi,
  output logic [15:0]      rx,
  output logic             done
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    rx = 16'h0000;
    done = 1'b0;
  end

  // The serial clock idles low and only runs inside a frame.
  always @(posedge ref_clk) begin
    if (go) begin
      #7;  // Off-phase start keeps the link unrelated to ref_clk.
      rx = 16'h0000;
      sel_n = 1'b0;
      #200;
      for (int i = 0; i < n_bits; i++) begin
        sclk = 1'b1;
        sdi = tx[n_bits-1-i];
        #100;
        sclk = 1'b0;
        #100;
        rx = {rx[14:0], sdo_w};
      end
      sel_n = 1'b1;
      sdi = ~sdi;  // A released line must not keep showing the last bit.
      done = 1'b1;
      @(posedge ref_clk);
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/octal_serial_driver_control_tb.sv
/*
  Self-checking bench of the serial driver control core.
  Assumes the host model in sim/ and the package in common/.
*/
`timescale 1ns/1ps
`default_nettype none
module octal_serial_driver_control_tb;
  import osdc_pkg::*;
  typedef struct packed {
    logic [15:0] rx;
    logic [7:0]  drv;
  } osdc_exp_t;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              go = 1'b0;
  logic              sel_n, sclk, sdi, sdo, sdo_oe, done;
  logic [4:0]        n_b = 5'h08;
  logic [15:0]       tx_b = 16'h0000;
  logic [15:0]       rx;
  logic [CHAN_N-1:0] drv_on, drv_prev;
  logic [CHAN_N-1:0] out_high = 8'h00;
  logic [CHAN_N-1:0] fault_threshold = 8'h00;
  logic [CHAN_N-1:0] load = 8'hAD;   // Bits 6, 4 and 1 open: read low.
  logic [CHAN_N-1:0] short_m = 8'h00;
  logic [CHAN_N-1:0] exp_on = 8'h00;  // Expected drive state.
  wire               sdo_w;
  int                failures = 0;
  int                n_tests = 0;
  int                k;
  osdc_exp_t         q[$];
  osdc_exp_t         e;

  // An undriven wire reads as z, so it can never pass for data.
  assign sdo_w = sdo_oe ? sdo : 1'bz;

  always #12.5 ref_clk = ~ref_clk;

  osdc_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sel_n(sel_n),
    .sclk(sclk), .sdi(sdi), .out_high(out_high),
    .fault_threshold(fault_threshold), .sdo(sdo), .sdo_oe(sdo_oe),
    .drv_on(drv_on));

  osdc_host_model u_host (.ref_clk(ref_clk), .go(go), .n_bits(n_b),
    .tx(tx_b), .sdo_w(sdo_w), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
    .rx(rx), .done(done));

  // Load model: ON pins sit low unless shorted; OFF pins need a load.
  always @(posedge ref_clk) begin
    out_high <= (~drv_on & load) | (drv_on & short_m);
    fault_threshold <= drv_on & short_m;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One frame: note the expectation, run it, wait a bounded time.
  task automatic frame(input logic [4:0] n, input logic [15:0] t);
    logic [7:0] dg;
    int         w;
    dg = (~exp_on & load) | (exp_on & short_m);
    q.push_back({(n == 5'h10) ? {dg, t[15:8]} : {8'h00, dg}, ~t[7:0]});
    exp_on = ~t[7:0];
    n_b <= n;
    tx_b <= t;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 3000) begin
      @(posedge ref_clk);
      w++;
    end
    if (w >= 3000) begin
      failures++;
      $display("[FAIL] %0t frame timed out", $time);
      results();
    end
    repeat (14) @(posedge ref_clk);
  endtask

  // Takes the oldest note as a frame completes and checks its results.
  always @(posedge ref_clk) begin
    if (done === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk(rx, e.rx, "bits out");
      repeat (10) @(posedge ref_clk);
      chk({8'h00, drv_on}, {8'h00, e.drv}, "outputs");
      chk({15'h0000, sdo_oe}, 16'h0000, "enable");
    end
  end

  // Outputs must hold still while selected, whatever the shifting does.
  // Sampled on the falling edge, where the outputs have settled.
  always @(negedge ref_clk) begin
    drv_prev <= drv_on;
    if (rst_n && !sel_n && drv_on !== drv_prev) begin
      failures++;
      $display("[FAIL] %0t outputs moved while selected", $time);
    end
  end

  initial begin
    void'($urandom(52));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk({8'h00, drv_on}, 16'h0000, "reset");
    @(posedge ref_clk);
    for (int c = 0; c < 8; c++) frame(5'h08, {8'h00, ~(8'h01 << c)});
    $display("test walk done");
    repeat (6) frame(5'h08, {8'h00, 8'($urandom)});
    $display("test random done");
    frame(5'h10, 16'($urandom));
    frame(5'h10, 16'($urandom));
    $display("test cascade done");
    frame(5'h08, 16'h00F7);
    short_m <= 8'h08;  // Channel 3 is ON and its pin now shorted high.
    k = 0;
    while (drv_on[3] === 1'b1 && k < FAULT_CLEAR_MAX_CYC) begin
      @(posedge ref_clk);
      k++;
    end
    if (drv_on[3] === 1'b1) begin
      failures++;
      $display("[FAIL] %0t fault clear timed out", $time);
      results();
    end
    chk({15'h0000, k + 14 >= FAULT_CLEAR_MIN_CYC}, 16'h0001, "early");
    chk({8'h00, drv_on}, 16'h0000, "fault off");
    exp_on[3] = 1'b0;
    short_m <= 8'h00;
    @(posedge ref_clk);
    frame(5'h08, 16'h00FF);
    $display("test fault done");
    frame(5'h08, 16'h0000);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({7'h00, drv_on, sdo_oe}, 16'h0000, "mid reset");
    rst_n <= 1'b1;
    exp_on = 8'h00;
    @(posedge ref_clk);
    frame(5'h08, 16'h005A);
    $display("test reset done");
    results();
  end
endmodule
`default_nettype wire
